//--- core/hbr_control_regs.sv
// Serial-programmed control register bank and switch drive of a twelve-bridge driver.
`default_nettype none
module hbr_control_regs (
	input  wire logic                  mclk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire logic                  cs_n_i,
	input  wire logic                  sclk_i,
	input  wire logic                  sdi_i,
	input  wire logic [2:0]            pwm_ch_i,
	output logic                       sdo_o,
	output logic                       sdo_oe_o,
	output var hbr_pkg::hbr_switch_type switch_o
);
	import hbr_pkg::*;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic hbr_addr_type decode_addr(input logic [7:0] a);
		hbr_addr_type r;
		r.valid = (a[PAD_LSB +: 2] == PAD_VALUE) && a[TAIL_BIT];
		r.idx   = IDX_ACT1;
		if (a[CODE_LSB +: 3] == CODE_ACT1) begin
			r.idx = IDX_ACT1;
		end else if (a[CODE_LSB +: 3] == CODE_ACT2) begin
			r.idx = IDX_ACT2;
		end else if (a[CODE_LSB +: 3] == CODE_ACT3) begin
			r.idx = IDX_ACT3;
		end else if (a[CODE_LSB +: 3] == CODE_MODE1) begin
			r.idx = IDX_MODE1;
		end else begin
			r.valid = 1'b0;
		end
		return r;
	endfunction : decode_addr

	function automatic logic pwm_gate(input logic [1:0] mode, input logic [2:0] pwm);
		logic g;
		g = 1'b1;
		case (mode)
			MODE_CH1: g = pwm[0];
			MODE_CH2: g = pwm[1];
			MODE_CH3: g = pwm[2];
			default:  g = 1'b1;
		endcase
		return g;
	endfunction : pwm_gate

	function automatic logic [1:0] bridge_pair(input logic [NUM_REGS-1:0][7:0] regs, input int b);
		logic [1:0] p;
		p = regs[b / PER_REG][2 * (b % PER_REG) +: 2];
		return p;
	endfunction : bridge_pair

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	hbr_state_type st;
	hbr_state_type next_st;
	logic          cs_rise;
	logic          cs_fall;
	logic          sclk_rise;
	logic          sclk_fall;
	logic          frame_ok;
	logic [7:0]    cmd_addr;
	logic [7:0]    cmd_data;
	hbr_addr_type  cmd_dec;

	assign cs_rise   = st.cs_s2 & ~st.cs_prev;
	assign cs_fall   = ~st.cs_s2 & st.cs_prev;
	assign sclk_rise = st.sclk_s2 & ~st.sclk_prev;
	assign sclk_fall = ~st.sclk_s2 & st.sclk_prev;
	assign cmd_addr  = st.in_sr[ADDR_LSB +: 8];
	assign cmd_data  = st.in_sr[DATA_LSB +: 8];
	assign cmd_dec   = decode_addr(cmd_addr);
	assign frame_ok  = ce_i & cs_rise & (st.bit_cnt == FRAME_BITS);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       lo;
		logic       hi;
		logic [1:0] mode;
		logic [7:0] answer;
		next_st = st;
		lo      = 1'b0;
		hi      = 1'b0;
		mode    = MODE_NONE;
		answer  = READ_UNMAP;
		if (ce_i) begin
			// The first stage of each pin feeds only the second stage.
			next_st.cs_s1     = cs_n_i;
			next_st.cs_s2     = st.cs_s1;
			next_st.cs_prev   = st.cs_s2;
			next_st.sclk_s1   = sclk_i;
			next_st.sclk_s2   = st.sclk_s1;
			next_st.sclk_prev = st.sclk_s2;
			next_st.sdi_s1    = sdi_i;
			next_st.sdi_s2    = st.sdi_s1;
			if (cs_fall) begin
				next_st.bit_cnt = '0;
				next_st.sdo_oe  = 1'b1;
				next_st.sdo     = st.out_sr[0];
			end else if (!st.cs_s2 && sclk_rise) begin
				// Address byte first, least significant bit first.
				next_st.in_sr = {st.sdi_s2, st.in_sr[15:1]};
				if (st.bit_cnt != FRAME_OVER) begin
					next_st.bit_cnt = st.bit_cnt + 5'h01;
				end
			end else if (!st.cs_s2 && sclk_fall) begin
				next_st.out_sr = {1'b0, st.out_sr[15:1]};
				next_st.sdo    = st.out_sr[1];
			end
			if (cs_rise) begin
				next_st.sdo_oe = 1'b0;
			end
			if (frame_ok) begin
				if (cmd_dec.valid) begin
					answer = st.regs[cmd_dec.idx];
					if (cmd_addr[OP_BIT]) begin
						next_st.regs[cmd_dec.idx] = cmd_data;
						answer = cmd_data;
					end
				end
				// The answer is shifted out during the next frame, so a
				// read costs two frames; this keeps the shifter simple.
				next_st.out_sr = {answer, cmd_addr};
			end
			for (int b = 0; b < NUM_BRIDGES; b++) begin
				{hi, lo} = bridge_pair(st.regs, b);
				mode = MODE_NONE;
				// Mode fields for bridges one to four.
				if (b < MODE_BRIDGES) begin
					mode = st.regs[IDX_MODE1][2 * b +: 2];
				end
				next_st.sw.high_side_switch[b] = hi & ~lo & pwm_gate(mode, pwm_ch_i);
				next_st.sw.low_side_switch[b]  = lo & ~hi & pwm_gate(mode, pwm_ch_i);
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset value
	// ----------------------------------------------------------------
	// The chip-select stages start at the idle level so that release shows no false edge.
	localparam hbr_state_type ST_RESET = '{
		cs_s1:     1'b1,
		cs_s2:     1'b1,
		cs_prev:   1'b1,
		sclk_s1:   1'b0,
		sclk_s2:   1'b0,
		sclk_prev: 1'b0,
		sdi_s1:    1'b0,
		sdi_s2:    1'b0,
		bit_cnt:   5'h00,
		in_sr:     16'h0000,
		out_sr:    16'h0000,
		sdo:       1'b0,
		sdo_oe:    1'b0,
		regs:      {NUM_REGS{REG_RESET}},
		sw:        '0
	};

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign sdo_o    = st.sdo;
	assign sdo_oe_o = st.sdo_oe;
	assign switch_o = st.sw;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [NUM_BRIDGES-1:0] hs_req;
	logic [NUM_BRIDGES-1:0] ls_req;
	logic [MODE_BRIDGES-1:0] wave;

	always_comb begin
		hs_req = '0;
		ls_req = '0;
		wave   = '1;
		// The requests are rebuilt from the registers, not taken from the drive logic.
		for (int b = 0; b < NUM_BRIDGES; b++) begin
			{hs_req[b], ls_req[b]} = bridge_pair(st.regs, b);
		end
		for (int k = 0; k < MODE_BRIDGES; k++) begin
			if (st.regs[IDX_MODE1][2 * k +: 2] != MODE_NONE) begin
				wave[k] = pwm_ch_i[st.regs[IDX_MODE1][2 * k +: 2] - 2'h1];
			end
		end
	end

	a_reset_regs_zero: assert property (@(posedge mclk_i) rst_i |=> (st.regs == '0))
		else $error("Registers not zero after reset.");

	a_bad_frame_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && cs_rise && st.bit_cnt != FRAME_BITS) |=> $stable(st.regs))
		else $error("Partial frame changed a register.");

	a_no_self_change: assert property (@(posedge mclk_i) disable iff (rst_i)
		!frame_ok |=> $stable(st.regs))
		else $error("Register changed without a command.");

	a_read_keeps_reg: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && !cmd_addr[OP_BIT]) |=> $stable(st.regs) ##1 $stable(st.regs))
		else $error("Read command altered a register.");

	a_write_lands: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && cmd_addr[OP_BIT] && cmd_dec.valid)
		|=> (st.regs[$past(cmd_dec.idx)] == $past(cmd_data)))
		else $error("Write data did not land.");

	a_cross_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> (((st.sw.high_side_switch | st.sw.low_side_switch) & $past(hs_req & ls_req)) == '0))
		else $error("Both switches of a bridge driven.");

	a_high_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> (st.sw.high_side_switch[11:4] == $past(hs_req[11:4] & ~ls_req[11:4])))
		else $error("High switch does not follow enable.");

	a_low_follows: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> (st.sw.low_side_switch[11:4] == $past(ls_req[11:4] & ~hs_req[11:4])))
		else $error("Low switch does not follow enable.");

	a_pwm_gated: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> (st.sw.high_side_switch[3:0] == $past(hs_req[3:0] & ~ls_req[3:0] & wave)))
		else $error("PWM gating of high switch wrong.");

	a_act2_decode: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && cmd_addr == 8'hc1) |=> (st.regs[IDX_ACT2] == $past(cmd_data)))
		else $error("Second activation register not written.");

	a_mode1_decode: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && cmd_addr == 8'he3) |=> (st.regs[IDX_MODE1] == $past(cmd_data)))
		else $error("Mode register not written.");

	a_sdo_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && cs_rise) |=> !sdo_oe_o [*2])
		else $error("Serial output driven outside a frame.");

	a_sdo_first_bit: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && cs_fall) |=> (sdo_o == $past(st.out_sr[0])))
		else $error("First answer bit not presented.");

	a_frame_count: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && !cs_fall && !st.cs_s2 && sclk_rise && st.bit_cnt != FRAME_OVER) |=> (st.bit_cnt == $past(st.bit_cnt) + 5'h01))
		else $error("Serial bit count did not advance.");

	a_read_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && !cmd_addr[OP_BIT] && cmd_dec.valid) |=> (st.out_sr[15:8] == $past(st.regs[cmd_dec.idx])))
		else $error("Read answer is not the register content.");

	a_act1_decode: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && cmd_addr == 8'h81) |=> (st.regs[IDX_ACT1] == $past(cmd_data)))
		else $error("First activation register not written.");

	a_unmapped_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && !cmd_dec.valid) |=> $stable(st.regs))
		else $error("Unmapped address changed a register.");

	a_act3_decode: assert property (@(posedge mclk_i) disable iff (rst_i)
		(frame_ok && cmd_addr == 8'ha1) |=> (st.regs[IDX_ACT3] == $past(cmd_data)))
		else $error("Third activation register not written.");

	a_ce_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ce_i |=> $stable(st))
		else $error("State moved while the clock enable was low.");

	a_reset_outputs: assert property (@(posedge mclk_i) rst_i |=> (st.sw == '0 && !st.sdo_oe))
		else $error("Outputs not idle after reset.");

	// ----------------------------------------------------------------
	// Switch drive checks
	// ----------------------------------------------------------------
	a_bank1_pairs: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> (st.sw.low_side_switch[3:0] == $past(ls_req[3:0] & ~hs_req[3:0] & wave)))
		else $error("Low switches of bridges one to four wrong.");

	a_bank2_pairs: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> ({st.sw.high_side_switch[7:4], st.sw.low_side_switch[7:4]}
			== $past({hs_req[7:4] & ~ls_req[7:4], ls_req[7:4] & ~hs_req[7:4]})))
		else $error("Switches of bridges five to eight wrong.");

	a_bank3_pairs: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i |=> ({st.sw.high_side_switch[11:8], st.sw.low_side_switch[11:8]}
			== $past({hs_req[11:8] & ~ls_req[11:8], ls_req[11:8] & ~hs_req[11:8]})))
		else $error("Switches of bridges nine to twelve wrong.");

	a_mode_none_on: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && st.regs[IDX_MODE1][1:0] == MODE_NONE) |=> (st.sw.high_side_switch[0] == $past(hs_req[0] & ~ls_req[0])))
		else $error("Unmodulated bridge one not steady.");

	a_mode_field_four: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && st.regs[IDX_MODE1][7:6] == MODE_CH3)
		|=> (st.sw.high_side_switch[3] == $past(hs_req[3] & ~ls_req[3] & pwm_ch_i[2])))
		else $error("Bridge four not gated by channel three.");
endmodule : hbr_control_regs
`default_nettype wire

//--- core/hbr_pkg.sv
// Shared constants and types of the half-bridge control register bank.
`default_nettype none
package hbr_pkg;
	// ----------------------------------------------------------------
	// Frame and address byte layout
	// ----------------------------------------------------------------
	localparam logic [4:0] FRAME_BITS  = 5'h10;
	localparam logic [4:0] FRAME_OVER  = 5'h11;
	localparam int         OP_BIT      = 7;
	localparam int         CODE_LSB    = 4;
	localparam int         PAD_LSB     = 2;
	localparam int         LAST_ADDRESS_BIT_TOKEN_BIT    = 1;
	localparam int         TAIL_BIT    = 0;
	localparam int         ADDR_LSB    = 0;
	localparam int         DATA_LSB    = 8;
	localparam logic [1:0] PAD_VALUE   = 2'h0;
	localparam logic [2:0] CODE_ACT1   = 3'h0;
	localparam logic [2:0] CODE_ACT2   = 3'h4;
	localparam logic [2:0] CODE_ACT3   = 3'h2;
	localparam logic [2:0] CODE_MODE1  = 3'h6;
	localparam logic [1:0] IDX_ACT1    = 2'h0;
	localparam logic [1:0] IDX_ACT2    = 2'h1;
	localparam logic [1:0] IDX_ACT3    = 2'h2;
	localparam logic [1:0] IDX_MODE1   = 2'h3;
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam logic [7:0] READ_UNMAP  = 8'h00;
	// ----------------------------------------------------------------
	// Bridge and PWM layout
	// ----------------------------------------------------------------
	localparam int         NUM_REGS    = 4;
	localparam int         NUM_BRIDGES = 12;
	localparam int         PER_REG     = 4;
	localparam int         NUM_PWM     = 3;
	localparam int         MODE_BRIDGES = 4;
	localparam logic [1:0] MODE_NONE   = 2'h0;
	localparam logic [1:0] MODE_CH1    = 2'h1;
	localparam logic [1:0] MODE_CH2    = 2'h2;
	localparam logic [1:0] MODE_CH3    = 2'h3;

	typedef struct packed {
		logic                   valid;
		logic [1:0]             idx;
	} hbr_addr_type;

	typedef struct packed {
		logic [NUM_BRIDGES-1:0] high_side_switch;
		logic [NUM_BRIDGES-1:0] low_side_switch;
	} hbr_switch_type;

	typedef struct packed {
		logic                   cs_s1;
		logic                   cs_s2;
		logic                   cs_prev;
		logic                   sclk_s1;
		logic                   sclk_s2;
		logic                   sclk_prev;
		logic                   sdi_s1;
		logic                   sdi_s2;
		logic [4:0]             bit_cnt;
		logic [15:0]            in_sr;
		logic [15:0]            out_sr;
		logic                   sdo;
		logic                   sdo_oe;
		logic [NUM_REGS-1:0][7:0] regs;
		hbr_switch_type         sw;
	} hbr_state_type;
endpackage : hbr_pkg
`default_nettype wire

//--- verif/hbr_control_regs_tb.sv
// Self-checking testbench of the half-bridge control register bank.
`default_nettype none
module hbr_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hbr_pkg::*;

	logic           mclk;
	logic           rst;
	logic           ce;
	logic           cs_n;
	logic           sclk;
	logic           sdi;
	logic           sdo;
	logic           sdo_oe;
	logic [2:0]     pwm_ch;
	hbr_switch_type sw;
	logic [7:0]     shadow [4];
	logic [15:0]    rx;
	int             err_total  = 0;
	int             n_compared = 0;
	int             cycles     = 0;
	localparam logic [7:0] WR_ADDR [4] = '{8'h81, 8'hc1, 8'ha1, 8'he1};

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	hbr_control_regs dut (
		.mclk_i   (mclk),
		.rst_i    (rst),
		.ce_i     (ce),
		.cs_n_i   (cs_n),
		.sclk_i   (sclk),
		.sdi_i    (sdi),
		.pwm_ch_i (pwm_ch),
		.sdo_o    (sdo),
		.sdo_oe_o (sdo_oe),
		.switch_o (sw)
	);

	hbr_host_model host (
		.mclk_i (mclk),
		.sdo_i  (sdo),
		.cs_n_o (cs_n),
		.sclk_o (sclk),
		.sdi_o  (sdi)
	);

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// Expected drive: a bridge with both enables set is off; mode fields exist for bridges 1 to 4 only.
	function automatic hbr_switch_type exp_sw(input logic [2:0] p);
		hbr_switch_type e;
		logic [23:0]    en;
		logic [1:0]     m;
		logic           g;
		en = {shadow[2], shadow[1], shadow[0]};
		for (int b = 0; b < 12; b++) begin
			m = (b < 4) ? shadow[3][2*b +: 2] : 2'h0;
			g = (m == 2'h0) ? 1'b1 : p[m - 2'h1];
			e.low_side_switch[b]  = en[2*b] & ~en[2*b+1] & g;
			e.high_side_switch[b] = en[2*b+1] & ~en[2*b] & g;
		end
		return e;
	endfunction : exp_sw

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic wr_sw(input int idx, input logic [7:0] d);
		host.xfer(WR_ADDR[idx], d, rx);
		shadow[idx] = d;
		check(sw, exp_sw(pwm_ch));
	endtask : wr_sw

	// A read carries data 0xff, which must not land in the register.
	task automatic rd_check(input int idx);
		host.xfer(WR_ADDR[idx] & 8'h7f, 8'hff, rx);
		host.xfer(8'h00, 8'h00, rx);
		check({8'h00, rx}, {8'h00, shadow[idx], WR_ADDR[idx] & 8'h7f});
	endtask : rd_check

	task automatic pwm_sweep;
		for (int p = 0; p < 8; p++) begin
			pwm_ch = p[2:0];
			repeat (2) @(negedge mclk);
			check(sw, exp_sw(pwm_ch));
		end
	endtask : pwm_sweep

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst    = 1'b1;
		ce     = 1'b1;
		pwm_ch = 3'h0;
		shadow = '{default: 8'h00};
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (8) @(negedge mclk);
		check(sw, 24'h000000);
		check({23'h000000, sdo_oe}, 24'h000000);
		for (int i = 0; i < 4; i++) rd_check(i);
		wr_sw(0, 8'h55);
		wr_sw(0, 8'haa);
		wr_sw(0, 8'h5f);
		wr_sw(1, 8'h5a);
		wr_sw(2, 8'h96);
		rd_check(0);
		rd_check(1);
		rd_check(2);
		host.xfer(8'h85, 8'hff, rx);
		host.xfer(8'h80, 8'hff, rx);
		check({8'h00, rx}, 24'h000085);
		host.xfer(8'h00, 8'h00, rx);
		check({8'h00, rx}, 24'h000080);
		check(sw, exp_sw(pwm_ch));
		repeat (200) @(negedge mclk);
		check(sw, exp_sw(pwm_ch));
		wr_sw(0, 8'h55);
		host.xfer(8'he3, 8'h1b, rx);
		shadow[3] = 8'h1b;
		check(sw, exp_sw(pwm_ch));
		wr_sw(3, 8'he4);
		pwm_sweep();
		wr_sw(0, 8'haa);
		pwm_sweep();
		rd_check(3);
		ce     = 1'b0;
		pwm_ch = 3'h0;
		repeat (4) @(negedge mclk);
		check(sw, exp_sw(3'h7));
		ce = 1'b1;
		repeat (2) @(negedge mclk);
		check(sw, exp_sw(pwm_ch));
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst    = 1'b0;
		shadow = '{default: 8'h00};
		repeat (8) @(negedge mclk);
		check(sw, 24'h000000);
		rd_check(3);
		tally_and_finish();
	end
endmodule : hbr_control_regs_tb
`default_nettype wire

//--- verif/hbr_host_model.sv
// Host side model: serial link master that sends one command frame at a time.
`default_nettype none
module hbr_host_model (
	input  wire logic mclk_i,
	input  wire logic sdo_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      sdi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b1;
	end

	// ----------------------------------------------------------------
	// Frame transfer
	// ----------------------------------------------------------------
	// sixteen bit command
	// Each clock half lasts six cycles so the synchronised edges have settled before sampling.
	task automatic xfer(input logic [7:0] addr, input logic [7:0] data, output logic [15:0] rx);
		logic [15:0] tx;
		tx = {data, addr};
		@(negedge mclk_i);
		cs_n_o = 1'b0;
		repeat (4) @(negedge mclk_i);
		for (int i = 0; i < 16; i++) begin
			sdi_o = tx[i];
			repeat (6) @(negedge mclk_i);
			rx[i] = sdo_i;
			sclk_o = 1'b1;
			repeat (6) @(negedge mclk_i);
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge mclk_i);
		cs_n_o = 1'b1;
		// The released data line flips so that a stale bit is never taken for a driven one.
		sdi_o = ~sdi_o;
		repeat (8) @(negedge mclk_i);
	endtask : xfer
endmodule : hbr_host_model
`default_nettype wire
